// ==== common/erxd_pkg.sv ====
// erxd_pkg: shared constants and types of the receive descriptor engine
// Function
// - in MII mode flag dribble error when frame holds an odd nibble count
// - flag CRC error for a failed check, meaningful only on a last descriptor
// - with extended features, bit zero flags extended status; dropped when bit 30 set
// - with full offload, set extended flag even when checksum engine skipped frame
// - otherwise bit zero shows address match by filter entries 1 to 15, cleared for 0
// - control bit 31 on frame-ending descriptor suppresses rx complete status
// - ring end flag makes next fetch come from list base address
// - chained flag makes word three the next pointer; buffer two size ignored
// - ring end takes priority over chaining
// - zero buffer one size skips buffer one, then buffer two or next descriptor
// - word two is buffer one physical start address
// - in chained operation word three is next descriptor address
// - set last descriptor flag on descriptor holding frame end
package erxd_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_CUR_DESC = 8'h10;
  localparam logic [7:0] REG_FRAME_CNT = 8'h14;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MII_MODE = 1;
  localparam int CTRL_EXT_MODE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam int IRQ_RX_COMPLETE = 0;
  // descriptor control word fields
  localparam int CW_IRQ_SUPPRESS = 31;
  localparam int CW_RING_END = 15;
  localparam int CW_CHAINED = 14;
  localparam int CW_BUF2_SIZE_LSB = 16;
  localparam int SIZE_W = 13;
  // descriptor status word fields
  localparam int SW_LAST = 8;
  localparam int SW_DRIBBLE = 2;
  localparam int SW_CRC_ERR = 1;
  localparam int SW_EXT_OR_ADDR = 0;
  localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_BUF1  = 6'b000100,
    ST_BUF2  = 6'b001000,
    ST_WBACK = 6'b010000,
    ST_HOLD  = 6'b100000
  } erxd_state_t;
endpackage

// ==== common/erxd_desc_if.sv ====
// erxd_desc_if: descriptor words in, buffer plan out
`timescale 1ns/1ps
interface erxd_desc_if;
  logic [31:0] ctrlWord;
  logic [31:0] buf1Word;
  logic [31:0] nextWord;
  logic [31:0] curAddr;
  logic [31:0] baseAddr;
  logic use1;
  logic use2;
  logic [12:0] buf1Size;
  logic [12:0] buf2Size;
  logic [31:0] buf1Addr;
  logic [31:0] buf2Addr;
  logic [31:0] nextAddr;
  logic suppressIrq;
  modport decoder (input ctrlWord, buf1Word, nextWord, curAddr, baseAddr,
    output use1, use2, buf1Size, buf2Size, buf1Addr, buf2Addr, nextAddr, suppressIrq);
  modport engine (output ctrlWord, buf1Word, nextWord, curAddr, baseAddr,
    input use1, use2, buf1Size, buf2Size, buf1Addr, buf2Addr, nextAddr, suppressIrq);
endinterface

// ==== rtl/erxd_desc_decode.sv ====
// erxd_desc_decode: turns a fetched descriptor into a buffer plan
`timescale 1ns/1ps
module erxd_desc_decode (
  input wire logic clk,
  input wire logic reset_n,
  erxd_desc_if.decoder d
);
  logic ringEnd;
  logic chained;
  // reserved control bits
  // only named fields are looked at; reserved bits never steer anything
  assign ringEnd = d.ctrlWord[erxd_pkg::CW_RING_END];
  assign chained = d.ctrlWord[erxd_pkg::CW_CHAINED];
  assign d.buf1Size = d.ctrlWord[erxd_pkg::SIZE_W-1:0];
  assign d.buf2Size = d.ctrlWord[erxd_pkg::CW_BUF2_SIZE_LSB +: erxd_pkg::SIZE_W];
  assign d.buf1Addr = d.buf1Word;
  assign d.buf2Addr = d.nextWord;
  assign d.use1 = (d.buf1Size != 13'h0000);
  assign d.use2 = !chained && (d.buf2Size != 13'h0000);
  assign d.suppressIrq = d.ctrlWord[erxd_pkg::CW_IRQ_SUPPRESS];
  always_comb begin
    if (ringEnd) begin
      d.nextAddr = d.baseAddr;
    end else if (chained) begin
      d.nextAddr = d.nextWord;
    end else begin
      d.nextAddr = d.curAddr + erxd_pkg::DESC_BYTES;
    end
  end

  a_ring_priority: assert property (@(posedge clk) disable iff (!reset_n)
    ringEnd |-> d.nextAddr == d.baseAddr) else $error("ring end did not wrap to base");
  a_chain_next: assert property (@(posedge clk) disable iff (!reset_n)
    (chained && !ringEnd) |-> (d.nextAddr == d.nextWord && !d.use2))
    else $error("chained descriptor misread");
endmodule // erxd_desc_decode

// ==== rtl/erxd_rx_desc.sv ====
// erxd_rx_desc: receive descriptor engine with apb registers and memory port
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module erxd_rx_desc (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameValid,
  input wire logic [15:0] frameLen,
  input wire logic frameCrcErr,
  input wire logic frameOddNibble,
  input wire logic [3:0] frameAddrIdx,
  input wire logic frameBit30,
  output logic frameReady,
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic bufValid,
  output logic [31:0] bufAddr,
  output logic [15:0] bufLen,
  input wire logic bufDone,
  output logic irq
);
  erxd_pkg::erxd_state_t state_q;
  logic [2:0] ctrl_q;
  logic [31:0] base_q;
  logic irqStatus_q;
  logic irqMask_q;
  logic [31:0] cur_q;
  logic [31:0] frameCnt_q;
  logic [1:0] wordIdx_q;
  logic [31:0] ctrlWord_q;
  logic [31:0] buf1Word_q;
  logic [31:0] nextWord_q;
  logic [15:0] rem_q;
  logic crcErr_q;
  logic oddNibble_q;
  logic [3:0] addrIdx_q;
  logic bit30_q;
  logic busy_q;
  logic apbAccess;
  logic apbWrite;
  logic frameTake;
  logic rxDone;
  logic isLast;
  logic [15:0] len1;
  logic [15:0] len2;
  logic [31:0] statusWord;
  erxd_desc_if dif ();

  assign dif.ctrlWord = ctrlWord_q;
  assign dif.buf1Word = buf1Word_q;
  assign dif.nextWord = nextWord_q;
  assign dif.curAddr = cur_q;
  assign dif.baseAddr = base_q;

  erxd_desc_decode u_decode (
    .clk(clk),
    .reset_n(reset_n),
    .d(dif.decoder)
  );

  // apb: one wait state so every answer comes from a flop
  assign apbAccess = psel && penable && !pready;
  // writes commit only at the completing edge, when pready is seen high
  assign apbWrite = psel && penable && pready && pwrite;
  assign frameTake = frameValid && frameReady;
  assign rxDone = (state_q == erxd_pkg::ST_WBACK) && memAck && memWrite;
  assign isLast = (rem_q == 16'h0000);
  assign len1 = (rem_q < {3'h0, dif.buf1Size}) ? rem_q : {3'h0, dif.buf1Size};
  assign len2 = (rem_q < {3'h0, dif.buf2Size}) ? rem_q : {3'h0, dif.buf2Size};

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[erxd_pkg::SW_LAST] = isLast;
    statusWord[erxd_pkg::SW_DRIBBLE] = isLast && oddNibble_q && ctrl_q[erxd_pkg::CTRL_MII_MODE];
    statusWord[erxd_pkg::SW_CRC_ERR] = isLast && crcErr_q;
    if (ctrl_q[erxd_pkg::CTRL_EXT_MODE]) begin
      // extended status flag, even for skipped frames
      statusWord[erxd_pkg::SW_EXT_OR_ADDR] = isLast && !bit30_q;
    end else begin
      // address match entries 1 to 15
      statusWord[erxd_pkg::SW_EXT_OR_ADDR] = isLast && (addrIdx_q != 4'h0);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbAccess;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apbAccess) begin
        unique case (paddr)
          erxd_pkg::REG_CTRL: prdata <= {29'h0, ctrl_q};
          erxd_pkg::REG_BASE: prdata <= base_q;
          erxd_pkg::REG_IRQ_STATUS: prdata <= {31'h0, irqStatus_q};
          erxd_pkg::REG_IRQ_MASK: prdata <= {31'h0, irqMask_q};
          erxd_pkg::REG_CUR_DESC: prdata <= cur_q;
          erxd_pkg::REG_FRAME_CNT: prdata <= frameCnt_q;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= erxd_pkg::CTRL_RESET;
      base_q <= erxd_pkg::BASE_RESET;
      irqMask_q <= 1'b0;
    end else if (apbWrite) begin
      if (paddr == erxd_pkg::REG_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end
      if (paddr == erxd_pkg::REG_BASE) begin
        base_q <= {pwdata[31:2], 2'b00};
      end
      if (paddr == erxd_pkg::REG_IRQ_MASK) begin
        irqMask_q <= pwdata[erxd_pkg::IRQ_RX_COMPLETE];
      end
    end
  end

  // sticky status: a completion in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_q <= 1'b0;
    end else if (rxDone && isLast && !dif.suppressIrq) begin
      irqStatus_q <= 1'b1;
    end else if (apbWrite && paddr == erxd_pkg::REG_IRQ_STATUS
                 && pwdata[erxd_pkg::IRQ_RX_COMPLETE]) begin
      irqStatus_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irqStatus_q && irqMask_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frameReady <= 1'b0;
    end else begin
      frameReady <= (state_q == erxd_pkg::ST_IDLE) && ctrl_q[erxd_pkg::CTRL_ENABLE] && !frameTake;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crcErr_q <= 1'b0;
      oddNibble_q <= 1'b0;
      addrIdx_q <= 4'h0;
      bit30_q <= 1'b0;
    end else if (frameTake) begin
      crcErr_q <= frameCrcErr;
      oddNibble_q <= frameOddNibble;
      addrIdx_q <= frameAddrIdx;
      bit30_q <= frameBit30;
    end
  end

  // the list pointer restarts at base whenever the engine is disabled and in idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= erxd_pkg::BASE_RESET;
      frameCnt_q <= 32'h0000_0000;
    end else if (!ctrl_q[erxd_pkg::CTRL_ENABLE] && state_q == erxd_pkg::ST_IDLE) begin
      cur_q <= base_q;
    end else if (rxDone) begin
      cur_q <= dif.nextAddr;
      if (isLast) begin
        frameCnt_q <= frameCnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= erxd_pkg::ST_IDLE;
      wordIdx_q <= 2'h0;
      ctrlWord_q <= 32'h0000_0000;
      buf1Word_q <= 32'h0000_0000;
      nextWord_q <= 32'h0000_0000;
      rem_q <= 16'h0000;
      busy_q <= 1'b0;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 32'h0000_0000;
      memWdata <= 32'h0000_0000;
      bufValid <= 1'b0;
      bufAddr <= 32'h0000_0000;
      bufLen <= 16'h0000;
    end else begin
      bufValid <= 1'b0;
      unique case (state_q)
        erxd_pkg::ST_IDLE: begin
          if (frameTake) begin
            rem_q <= frameLen;
            wordIdx_q <= 2'h0;
            state_q <= erxd_pkg::ST_FETCH;
          end
        end
        erxd_pkg::ST_FETCH: begin
          if (!memReq) begin
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memAddr <= cur_q + {28'h0, wordIdx_q, 2'b00};
          end else if (memAck) begin
            memReq <= 1'b0;
            unique case (wordIdx_q)
              2'h1: ctrlWord_q <= memRdata;
              2'h2: buf1Word_q <= memRdata;
              2'h3: nextWord_q <= memRdata;
              default: ;
            endcase
            wordIdx_q <= wordIdx_q + 2'h1;
            if (wordIdx_q == 2'h3) begin
              state_q <= erxd_pkg::ST_BUF1;
            end
          end
        end
        erxd_pkg::ST_BUF1: begin
          if (busy_q) begin
            if (bufDone) begin
              busy_q <= 1'b0;
              rem_q <= rem_q - bufLen;
              state_q <= erxd_pkg::ST_BUF2;
            end
          end else if (dif.use1 && !isLast) begin
            bufAddr <= dif.buf1Addr;
            bufLen <= len1;
            bufValid <= 1'b1;
            busy_q <= 1'b1;
          end else begin
            state_q <= erxd_pkg::ST_BUF2;
          end
        end
        erxd_pkg::ST_BUF2: begin
          if (busy_q) begin
            if (bufDone) begin
              busy_q <= 1'b0;
              rem_q <= rem_q - bufLen;
              state_q <= erxd_pkg::ST_HOLD;
            end
          // chained descriptors have no buffer two
          end else if (dif.use2 && !isLast) begin
            bufAddr <= dif.buf2Addr;
            bufLen <= len2;
            bufValid <= 1'b1;
            busy_q <= 1'b1;
          end else begin
            state_q <= erxd_pkg::ST_HOLD;
          end
        end
        erxd_pkg::ST_HOLD: begin
          // reserved status bits written as zero
          memReq <= 1'b1;
          memWrite <= 1'b1;
          memAddr <= cur_q;
          memWdata <= statusWord;
          state_q <= erxd_pkg::ST_WBACK;
        end
        erxd_pkg::ST_WBACK: begin
          if (memAck) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            wordIdx_q <= 2'h0;
            state_q <= isLast ? erxd_pkg::ST_IDLE : erxd_pkg::ST_FETCH;
          end
        end
        default: state_q <= erxd_pkg::ST_IDLE;
      endcase
    end
  end

  sequence s_wback_done;
    rxDone && isLast;
  endsequence

  a_irq_suppress: assert property (@(posedge clk) disable iff (!reset_n)
    (s_wback_done and dif.suppressIrq && !irqStatus_q) |=> !irqStatus_q)
    else $error("suppressed frame set rx complete");
  a_irq_set: assert property (@(posedge clk) disable iff (!reset_n)
    (s_wback_done and !dif.suppressIrq) |=> irqStatus_q ##1 (irq == $past(irqMask_q)))
    else $error("rx complete not raised");
  a_dribble_mode: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == erxd_pkg::ST_WBACK && !ctrl_q[erxd_pkg::CTRL_MII_MODE])
      |-> !memWdata[erxd_pkg::SW_DRIBBLE]) else $error("dribble outside mii");
  a_crc_last: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == erxd_pkg::ST_WBACK && memWdata[erxd_pkg::SW_CRC_ERR])
      |-> memWdata[erxd_pkg::SW_LAST]) else $error("crc flag on non-last");
  a_ext_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == erxd_pkg::ST_WBACK && ctrl_q[erxd_pkg::CTRL_EXT_MODE] && isLast)
      |-> memWdata[erxd_pkg::SW_EXT_OR_ADDR] == !bit30_q)
    else $error("extended flag wrong");
  a_addr_match: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == erxd_pkg::ST_WBACK && !ctrl_q[erxd_pkg::CTRL_EXT_MODE] && isLast)
      |-> memWdata[erxd_pkg::SW_EXT_OR_ADDR] == (addrIdx_q != 4'h0))
    else $error("address match flag wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (memReq && memWrite) |-> (memWdata & 32'hffff_fef8) == 32'h0000_0000)
    else $error("reserved status bit written");
  a_skip_buf1: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == erxd_pkg::ST_BUF1 && !busy_q && !dif.use1)
      |=> !bufValid && state_q == erxd_pkg::ST_BUF2) else $error("empty buffer one used");
  a_next_fetch: assert property (@(posedge clk) disable iff (!reset_n)
    rxDone |=> cur_q == $past(dif.nextAddr)) else $error("next descriptor address wrong");
endmodule // erxd_rx_desc

// ==== test/erxd_host_model.sv ====
// erxd_host_model: host memory and data mover facing the descriptor engine
`timescale 1ns/1ps
module erxd_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata,
  input wire logic bufValid,
  input wire logic [31:0] bufAddr,
  input wire logic [15:0] bufLen,
  output logic bufDone
);
  logic [31:0] mem [0:1023];
  logic [3:0] waitCnt;
  logic [3:0] bufCnt;
  logic busy;
  int nBuf;
  logic [31:0] lastBufAddr;
  logic [15:0] lastBufLen;

  // plain always: the bench preloads descriptors straight into mem
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memAck <= 1'b0;
      memRdata <= 32'h0;
      waitCnt <= 4'h0;
    end else if (memReq && !memAck && waitCnt < lat) begin
      waitCnt <= waitCnt + 4'h1;
      memRdata <= ~memRdata;
    end else if (memReq && !memAck) begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      if (memWrite) begin
        mem[memAddr[11:2]] <= memWdata;
      end else begin
        memRdata <= mem[memAddr[11:2]];
      end
    end else begin
      // read data is not held once the beat is over
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bufDone <= 1'b0;
      busy <= 1'b0;
      bufCnt <= 4'h0;
      nBuf <= 0;
      lastBufAddr <= 32'h0;
      lastBufLen <= 16'h0;
    end else if (bufValid) begin
      busy <= 1'b1;
      bufCnt <= 4'h0;
      nBuf <= nBuf + 1;
      lastBufAddr <= bufAddr;
      lastBufLen <= bufLen;
      bufDone <= 1'b0;
    end else if (busy && bufCnt >= lat) begin
      bufDone <= 1'b1;
      busy <= 1'b0;
    end else begin
      bufDone <= 1'b0;
      bufCnt <= bufCnt + 4'h1;
    end
  end
endmodule // erxd_host_model

// ==== test/erxd_rx_desc_tb.sv ====
// erxd_rx_desc_tb: register and descriptor scenarios for the receive descriptor engine
`timescale 1ns/1ps
module erxd_rx_desc_tb;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, memAddr, memWdata, memRdata, bufAddr;
  logic frameValid, frameCrcErr, frameOddNibble, frameBit30, frameReady;
  logic [15:0] frameLen, bufLen;
  logic [3:0] frameAddrIdx, lat;
  logic memReq, memWrite, memAck, bufValid, bufDone;
  int nErrors, totalChecks;

  erxd_rx_desc dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frameValid(frameValid), .frameLen(frameLen),
    .frameCrcErr(frameCrcErr), .frameOddNibble(frameOddNibble),
    .frameAddrIdx(frameAddrIdx), .frameBit30(frameBit30), .frameReady(frameReady),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memAck(memAck), .memRdata(memRdata), .bufValid(bufValid), .bufAddr(bufAddr),
    .bufLen(bufLen), .bufDone(bufDone), .irq(irq));

  erxd_host_model model (.clk(clk), .reset_n(reset_n), .lat(lat), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata), .bufValid(bufValid), .bufAddr(bufAddr), .bufLen(bufLen),
    .bufDone(bufDone));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      nErrors++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a write commits at the pready edge; irq follows one edge later
    repeat (2) @(posedge clk);
  endtask

  task automatic putDesc(input logic [31:0] a, input logic [31:0] w1, w2, w3);
    model.mem[a[11:2]] = 32'hffff_ffff;
    model.mem[a[11:2] + 10'h1] = w1;
    model.mem[a[11:2] + 10'h2] = w2;
    model.mem[a[11:2] + 10'h3] = w3;
  endtask

  task automatic sendFrame(input logic [15:0] len, input logic crc, odd, b30,
    input logic [3:0] idx);
    int n;
    frameValid <= 1'b1;
    frameLen <= len;
    frameCrcErr <= crc;
    frameOddNibble <= odd;
    frameBit30 <= b30;
    frameAddrIdx <= idx;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frameReady !== 1'b1 && n < 100);
    if (frameReady !== 1'b1) begin
      nErrors++;
    end
    frameValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frameReady !== 1'b1 && n < 500);
    if (frameReady !== 1'b1) begin
      nErrors++;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // generous bound: the whole sequence needs well under two thousand cycles
  initial begin
    #(40000 * 5);
    nErrors++;
    tally_and_finish();
  end

  initial begin
    nErrors = 0;
    totalChecks = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {frameValid, frameCrcErr, frameOddNibble, frameBit30} = 4'h0;
    frameLen = 16'h0;
    frameAddrIdx = 4'h0;
    lat = 4'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(8'h00, 1'b0, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(8'h04, 1'b0, 32'h0);
    chk("base reset", rd, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    // buffer sizes kept multiples of four
    putDesc(32'h100, 32'h6000_2040, 32'h0000_0400, 32'h0);
    putDesc(32'h110, 32'h8000_8040, 32'h0000_0500, 32'h0);
    apb(8'h04, 1'b1, 32'h100);
    apb(8'h0c, 1'b1, 32'h1);
    apb(8'h00, 1'b1, 32'h3);
    sendFrame(16'h28, 1'b1, 1'b1, 1'b0, 4'h3);
    chk("status word a", model.mem[64], 32'h107);
    chk("buffer one addr", model.lastBufAddr, 32'h400);
    chk("buffer one len", {16'h0, model.lastBufLen}, 32'h28);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(8'h10, 1'b0, 32'h0);
    chk("next desc seq", rd, 32'h110);
    apb(8'h08, 1'b1, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    lat <= 4'h3;
    sendFrame(16'h8, 1'b0, 1'b0, 1'b0, 4'h0);
    chk("status word b", model.mem[68], 32'h100);
    chk("buffer b addr", model.lastBufAddr, 32'h500);
    apb(8'h08, 1'b0, 32'h0);
    chk("suppressed status", rd, 32'h0);
    chk("suppressed irq", {31'h0, irq}, 32'h0);
    apb(8'h10, 1'b0, 32'h0);
    chk("ring return", rd, 32'h100);
    putDesc(32'h100, 32'h0000_4000, 32'h0000_0800, 32'h200);
    putDesc(32'h200, 32'h0000_c010, 32'h0000_0600, 32'h300);
    apb(8'h0c, 1'b1, 32'h0);
    apb(8'h00, 1'b1, 32'h5);
    sendFrame(16'hc, 1'b0, 1'b1, 1'b0, 4'h0);
    chk("non-last status", model.mem[64], 32'h0);
    chk("status word d", model.mem[128], 32'h101);
    chk("buffer count", model.nBuf, 32'h3);
    chk("buffer d addr", model.lastBufAddr, 32'h600);
    chk("buffer d len", {16'h0, model.lastBufLen}, 32'h0c);
    apb(8'h10, 1'b0, 32'h0);
    chk("ring over chain", rd, 32'h100);
    chk("masked irq", {31'h0, irq}, 32'h0);
    apb(8'h08, 1'b0, 32'h0);
    chk("masked status", rd, 32'h1);
    apb(8'h0c, 1'b1, 32'h1);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    apb(8'h08, 1'b1, 32'h1);
    putDesc(32'h100, 32'h0000_0040, 32'h0000_0700, 32'h0);
    sendFrame(16'h4, 1'b1, 1'b0, 1'b1, 4'h0);
    chk("ext dropped", model.mem[64], 32'h102);
    apb(8'h14, 1'b1, 32'h0);
    apb(8'h14, 1'b0, 32'h0);
    chk("frame count", rd, 32'h4);
    tally_and_finish();
  end
endmodule // erxd_rx_desc_tb
